// ===== dv/p5if_partner.sv
`timescale 1ns/100ps
module p5if_partner (
	input  wire logic       lclk,
	input  wire logic       cclk,
	input  wire logic       rmii,
	input  wire logic       gen_en,
	output logic            gen_clk,
	output logic            tx_en,
	output logic            tx_er,
	output logic      [3:0] tx_d,
	input  wire logic       rx_valid,
	input  wire logic       rx_error,
	input  wire logic [3:0] rx_d
);
	logic [3:0] send_q[$];
	logic [4:0] recv_q[$];
	logic [3:0] cur;
	logic [1:0] lo;
	logic       ph_tx;
	logic       ph_rx;
	initial begin
		gen_clk = 1'b0;
		tx_en = 1'b0;
		tx_d = 4'h0;
		ph_tx = 1'b0;
		ph_rx = 1'b0;
	end
	assign tx_er = 1'b0;
	always #80 gen_clk = gen_en ? ~gen_clk : 1'b0;
	// one nibble or dibit per clock
	task automatic launch();
		if (rmii && ph_tx) begin
			tx_d = {~tx_d[3:2], cur[3:2]};
			ph_tx = 1'b0;
		end else if (send_q.size() > 0) begin
			cur = send_q.pop_front();
			tx_en = 1'b1;
			tx_d = rmii ? {~tx_d[3:2], cur[1:0]} : cur;
			ph_tx = rmii;
		end else begin
			tx_en = 1'b0;
			tx_d = ~tx_d;
		end
	endtask
	always @(posedge lclk) if (!gen_en) #1 launch();
	always @(negedge lclk) if (gen_en) launch();
	always @(negedge cclk) begin
		if (rx_valid !== 1'b1) begin
			ph_rx = 1'b0;
		end else if (!rmii) begin
			recv_q.push_back({rx_error, rx_d});
		end else if (!ph_rx) begin
			lo = rx_d[1:0];
			ph_rx = 1'b1;
		end else begin
			recv_q.push_back({1'b0, rx_d[1:0], lo});
			ph_rx = 1'b0;
		end
	end
endmodule

// ===== dv/tb_port5_mii_rmii_interface.sv
`timescale 1ns/100ps
module tb_port5_mii_rmii_interface;
	localparam int N = 12;
	localparam int LIMIT = 40000;
	// Bits: rmii, mac, clock strap, reg valid, reg bit, 100M, half duplex, source
	localparam logic [7:0] CFGS [6] = '{8'h07, 8'h00, 8'h46, 8'hA5, 8'h9C, 8'hB5};
	logic       ref_clk, rst_n, pgen, gen_en, col_seen, full_seen;
	logic [7:0] cfg;
	logic       port5_tx_enable_pin, port5_tx_error_pin;
	logic [3:0] port5_tx_data_pins, port5_rx_data_pins, egress_data, ingress_data;
	logic       port5_tx_clock_pin_in, port5_tx_clock_pin_out, port5_tx_clock_pin_oe;
	logic       port5_rx_clock_pin_in, port5_rx_clock_pin_out, port5_rx_clock_pin_oe;
	logic       port5_collision_pin_in, port5_collision_pin_out, port5_collision_pin_oe;
	logic       port5_carrier_pin_in, port5_carrier_pin_out, port5_carrier_pin_oe;
	logic       port5_rx_valid_pin, port5_rx_error_pin, egress_error, egress_valid;
	logic       egress_ready, ingress_error, ingress_valid, carrier_seen, collision_seen;
	logic       link_clock_present, clock_source_ref_input;
	logic [4:0] ing_q[$];
	int         err_total, checks_done, cyc;

	always #2.5 ref_clk = ~ref_clk;

	assign port5_tx_clock_pin_in = port5_tx_clock_pin_oe ? port5_tx_clock_pin_out : pgen;
	assign port5_rx_clock_pin_in = port5_rx_clock_pin_oe ? port5_rx_clock_pin_out : pgen;
	assign port5_collision_pin_in = port5_collision_pin_oe ? port5_collision_pin_out : 1'b0;
	assign port5_carrier_pin_in = port5_carrier_pin_oe ? port5_carrier_pin_out
		: port5_tx_enable_pin;

	p5if_port5 dut (
		.ref_clk, .rst_n,
		.role_select_strap(cfg[6]),
		.clock_mode_strap(cfg[5]),
		.clock_source_strap(cfg[0]),
		.rmii_select_strap(cfg[7]),
		.clock_mode_reg_bit(cfg[3]),
		.clock_mode_reg_valid(cfg[4]),
		.speed_100(cfg[2]),
		.half_duplex(cfg[1]),
		.port5_tx_enable_pin, .port5_tx_error_pin, .port5_tx_data_pins,
		.port5_tx_clock_pin_in, .port5_tx_clock_pin_out, .port5_tx_clock_pin_oe,
		.port5_rx_clock_pin_in, .port5_rx_clock_pin_out, .port5_rx_clock_pin_oe,
		.port5_collision_pin_in, .port5_collision_pin_out, .port5_collision_pin_oe,
		.port5_carrier_pin_in, .port5_carrier_pin_out, .port5_carrier_pin_oe,
		.port5_rx_valid_pin, .port5_rx_error_pin, .port5_rx_data_pins,
		.egress_data, .egress_error, .egress_valid, .egress_ready,
		.ingress_data, .ingress_error, .ingress_valid,
		.carrier_seen, .collision_seen, .link_clock_present, .clock_source_ref_input
	);

	p5if_partner p (
		.lclk(cfg[7] ? port5_rx_clock_pin_in : port5_tx_clock_pin_in),
		.cclk(port5_rx_clock_pin_in),
		.rmii(cfg[7]),
		.gen_en(gen_en),
		.gen_clk(pgen),
		.tx_en(port5_tx_enable_pin),
		.tx_er(port5_tx_error_pin),
		.tx_d(port5_tx_data_pins),
		.rx_valid(port5_rx_valid_pin),
		.rx_error(port5_rx_error_pin),
		.rx_d(port5_rx_data_pins)
	);

	task automatic end_sim();
		if (err_total == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	function automatic logic [4:0] exp_out(input logic [4:0] w, input logic rmii);
		return rmii ? {1'b0, w[3:0]} : w;
	endfunction

	function automatic int half(input logic [7:0] c);
		return c[7] ? p5if_pkg::RMII_HALF : (c[2] ? p5if_pkg::MII_FAST_HALF
			: p5if_pkg::MII_SLOW_HALF);
	endfunction

	task automatic push(input logic [4:0] w);
		int n;
		@(negedge ref_clk);
		egress_data = w[3:0];
		egress_error = w[4];
		egress_valid = 1'b1;
		n = 0;
		while (egress_ready !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic run_cfg(input logic [7:0] c);
		logic       ce, phy, gn;
		logic [4:0] w;
		logic [4:0] sent[$];
		logic [3:0] nib[$];
		int         n;
		longint     t0;
		@(negedge ref_clk);
		cfg = c;
		rst_n = 1'b0;
		gen_en = 1'b0;
		p.send_q.delete();
		p.recv_q.delete();
		ing_q.delete();
		col_seen = 1'b0;
		full_seen = 1'b0;
		ce = c[4] ? c[3] : c[5];
		phy = !c[7] && !c[6];
		gn = c[7] ? !ce : c[6];
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		if (gn) begin
			repeat (40) @(negedge ref_clk);
			// Only normal-mode RMII waits for the reference; MII MAC-like runs at once
			if (c[7])
				chk(link_clock_present, 0, "running before reference");
			gen_en = 1'b1;
		end
		n = 0;
		while (link_clock_present !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(link_clock_present, 1, "never running");
		chk({port5_tx_clock_pin_oe, port5_rx_clock_pin_oe, port5_collision_pin_oe,
			port5_carrier_pin_oe}, {phy, phy || (c[7] && ce), phy, phy}, "directions");
		chk(clock_source_ref_input, c[0], "clock source");
		if (phy || (c[7] && ce)) begin
			@(posedge port5_rx_clock_pin_out);
			t0 = $time;
			@(posedge port5_rx_clock_pin_out);
			chk(32'(($time - t0) / 5), 2 * half(c), "clock period");
		end
		for (int i = 0; i < N; i++) begin
			nib.push_back(4'($urandom));
			p.send_q.push_back(nib[i]);
		end
		for (int i = 0; i < N; i++) begin
			w = 5'($urandom);
			sent.push_back(w);
			push(w);
		end
		@(negedge ref_clk);
		egress_valid = 1'b0;
		n = 0;
		while ((p.recv_q.size() < N || ing_q.size() < N) && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		for (int i = 0; i < N; i++) begin
			chk(p.recv_q[i], exp_out(sent[i], c[7]), "egress word");
			chk(ing_q[i], {1'b0, nib[i]}, "ingress word");
		end
		// Last unit still on the pins for up to one slow clock
		repeat (100) @(negedge ref_clk);
		chk(port5_rx_valid_pin, 0, "valid while empty");
		chk({carrier_seen, collision_seen}, 0, "status while idle");
		chk(full_seen, 1, "buffer never refused");
		if (phy)
			chk(col_seen, c[1], "collision");
	endtask

	always @(posedge ref_clk) begin
		if (ingress_valid === 1'b1)
			ing_q.push_back({ingress_error, ingress_data});
		if (port5_collision_pin_oe === 1'b1 && port5_collision_pin_out === 1'b1)
			col_seen = 1'b1;
		if (rst_n && egress_valid && egress_ready === 1'b0)
			full_seen = 1'b1;
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		gen_en = 1'b0;
		cfg = CFGS[0];
		egress_data = 4'h0;
		egress_error = 1'b0;
		egress_valid = 1'b0;
		err_total = 0;
		checks_done = 0;
		cyc = 0;
		void'($urandom(37));
		foreach (CFGS[i])
			run_cfg(CFGS[i]);
		end_sim();
	end
endmodule

// ===== src/p5if_fifo.sv
`timescale 1ns/100ps
module p5if_fifo #(
	parameter int W = 5,
	parameter int D = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic [AW:0]   next_count;
	logic          push;
	logic          pop;

	assign push       = in_valid && in_ready;
	assign pop        = out_valid && out_ready;
	assign out_valid  = count != '0;
	assign out_data   = mem[rd_ptr];
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count    <= next_count;
			// Registered so the ready seen by the source has no comb path
			in_ready <= next_count != (AW+1)'(D);
		end
	end
endmodule

// ===== src/p5if_pkg.sv
package p5if_pkg;
	// Local clock and interface clock rates
	localparam real REF_CLK_MHZ    = 200.0;
	localparam real MII_FAST_MHZ   = 25.0;
	localparam real MII_SLOW_MHZ   = 2.5;
	localparam real RMII_REF_MHZ   = 50.0;
	// Half periods of generated clocks, in ref_clk cycles
	localparam int  MII_FAST_HALF  = $rtoi(REF_CLK_MHZ / (2.0 * MII_FAST_MHZ));
	localparam int  MII_SLOW_HALF  = $rtoi(REF_CLK_MHZ / (2.0 * MII_SLOW_MHZ));
	localparam int  RMII_HALF      = $rtoi(REF_CLK_MHZ / (2.0 * RMII_REF_MHZ));
	localparam int  DIV_W          = 7;
	// 10 Mbit/s RMII repeats each dibit for this many reference clocks
	localparam int  RMII_SLOW_REP  = 10;
	localparam int  REP_W          = 4;
	localparam int  CLK_PRESENT_N  = 8;
	localparam int  STRAP_SETTLE   = 3;
	localparam int  CNT_W          = 4;
	localparam int  FIFO_DEPTH     = 8;
	localparam int  WORD_W         = 5;
	localparam int  SYNC_W         = 14;

	typedef enum logic [1:0] {
		p5if_mii_phy,
		p5if_mii_mac,
		p5if_rmii_clk,
		p5if_rmii_norm
	} p5if_mode_t;

	typedef enum logic [1:0] {
		p5if_st_cfg,
		p5if_st_clk,
		p5if_st_run
	} p5if_state_t;
endpackage

// ===== src/p5if_port5.sv
`timescale 1ns/100ps
// Overview of operation
// - MII role (PHY-like or MAC-like) comes from a strap caught at configuration.
// - PHY-like: tx pins are inputs; clocks, collision, carrier, rx pins driven.
// - MAC-like: rx pins feed the PHY; clocks, collision, carrier, tx pins are inputs.
// - MII moves one unencoded nibble per clock each way.
// - Each direction carries a valid qualifier; the error indicator goes both ways in MII, ingress only in RMII.
// - Half duplex: collision asserted when transmit and receive overlap.
// - RMII supports both 10 and 100 Mbit/s.
// - RMII uses two-bit paths each way on one shared reference clock.
// - Clock mode: 50 MHz reference generated and driven on the rx clock pin.
// - Normal mode: reference arrives on tx clock pin; operation waits for it.
// - A strap selects device clock source: reference input or 25 MHz crystal.
// - RMII clock or normal mode chosen by strap or configuration bit 7.
// - RMII has no role selection; wiring alone sets the cross-connection.
// - Facing a PHY in RMII, tx pins take PHY outputs, rx pins drive PHY inputs.
// - MII clocks run at 2.5 MHz for 10 and 25 MHz for 100 Mbit/s.
module p5if_port5 (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       role_select_strap,
	input  wire logic       clock_mode_strap,
	input  wire logic       clock_source_strap,
	input  wire logic       rmii_select_strap,
	input  wire logic       clock_mode_reg_bit,
	input  wire logic       clock_mode_reg_valid,
	input  wire logic       speed_100,
	input  wire logic       half_duplex,
	input  wire logic       port5_tx_enable_pin,
	input  wire logic       port5_tx_error_pin,
	input  wire logic [3:0] port5_tx_data_pins,
	input  wire logic       port5_tx_clock_pin_in,
	output logic            port5_tx_clock_pin_out,
	output logic            port5_tx_clock_pin_oe,
	input  wire logic       port5_rx_clock_pin_in,
	output logic            port5_rx_clock_pin_out,
	output logic            port5_rx_clock_pin_oe,
	input  wire logic       port5_collision_pin_in,
	output logic            port5_collision_pin_out,
	output logic            port5_collision_pin_oe,
	input  wire logic       port5_carrier_pin_in,
	output logic            port5_carrier_pin_out,
	output logic            port5_carrier_pin_oe,
	output logic            port5_rx_valid_pin,
	output logic            port5_rx_error_pin,
	output logic      [3:0] port5_rx_data_pins,
	input  wire logic [3:0] egress_data,
	input  wire logic       egress_error,
	input  wire logic       egress_valid,
	output logic            egress_ready,
	output logic      [3:0] ingress_data,
	output logic            ingress_error,
	output logic            ingress_valid,
	output logic            carrier_seen,
	output logic            collision_seen,
	output logic            link_clock_present,
	output logic            clock_source_ref_input
);
	logic [p5if_pkg::SYNC_W-1:0] sync_q;
	logic                        s_role, s_clkmode, s_src, s_rmii;
	logic                        s_col, s_crs, s_rxclk, s_txclk, s_txer, s_txen;
	logic [3:0]                  s_txd;
	p5if_pkg::p5if_state_t       state;
	p5if_pkg::p5if_mode_t        mode;
	logic [p5if_pkg::CNT_W-1:0]  cnt;
	logic                        cfg_mac, cfg_rmii, cfg_clkmode;
	logic                        txclk_d, rxclk_d;
	logic                        txclk_rise, rxclk_rise;
	logic [p5if_pkg::DIV_W-1:0]  div_cnt;
	logic [p5if_pkg::DIV_W-1:0]  half;
	logic                        gclk, next_gclk, gen_on, gen_rise;
	logic [p5if_pkg::REP_W-1:0]  lrep, srep;
	logic                        launch, sample, out_ph, in_ph;
	logic [1:0]                  in_low;
	logic [p5if_pkg::WORD_W-1:0] fifo_word;
	logic                        fifo_valid, pop;

	function automatic p5if_pkg::p5if_mode_t p5if_decode(input logic rmii,
		input logic mac, input logic clkmode);
		if (rmii) begin
			return clkmode ? p5if_pkg::p5if_rmii_clk : p5if_pkg::p5if_rmii_norm;
		end
		return mac ? p5if_pkg::p5if_mii_mac : p5if_pkg::p5if_mii_phy;
	endfunction

	function automatic logic p5if_is_gen(input p5if_pkg::p5if_mode_t m);
		return m == p5if_pkg::p5if_mii_phy || m == p5if_pkg::p5if_rmii_clk;
	endfunction

	p5if_sync #(
		.W (p5if_pkg::SYNC_W)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({role_select_strap, clock_mode_strap, clock_source_strap,
		           rmii_select_strap, port5_collision_pin_in, port5_carrier_pin_in,
		           port5_rx_clock_pin_in, port5_tx_clock_pin_in, port5_tx_error_pin,
		           port5_tx_enable_pin, port5_tx_data_pins}),
		.q       (sync_q)
	);

	assign {s_role, s_clkmode, s_src, s_rmii, s_col, s_crs, s_rxclk, s_txclk,
		s_txer, s_txen, s_txd} = sync_q;

	p5if_fifo #(
		.W (p5if_pkg::WORD_W),
		.D (p5if_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_data   ({egress_error, egress_data}),
		.in_valid  (egress_valid),
		.in_ready  (egress_ready),
		.out_data  (fifo_word),
		.out_valid (fifo_valid),
		.out_ready (pop)
	);

	assign mode = p5if_decode(cfg_rmii, cfg_mac, cfg_clkmode);

	// Configuration, clock wait, run
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= p5if_pkg::p5if_st_cfg;
			cnt         <= '0;
			cfg_mac     <= 1'b0;
			cfg_rmii    <= 1'b0;
			cfg_clkmode <= 1'b0;
		end else begin
			case (state)
				p5if_pkg::p5if_st_cfg: begin
					cnt <= cnt + 1'b1;
					if (cnt == p5if_pkg::CNT_W'(p5if_pkg::STRAP_SETTLE)) begin
						cfg_mac     <= s_role;
						cfg_rmii    <= s_rmii;
						cfg_clkmode <= clock_mode_reg_valid ? clock_mode_reg_bit : s_clkmode;
						cnt         <= '0;
						state       <= p5if_pkg::p5if_st_clk;
					end
				end
				p5if_pkg::p5if_st_clk: begin
					if (!cfg_rmii || cfg_clkmode) begin
						state <= p5if_pkg::p5if_st_run;
					end else if (txclk_rise) begin
						cnt <= cnt + 1'b1;
						if (cnt == p5if_pkg::CNT_W'(p5if_pkg::CLK_PRESENT_N - 1)) begin
							state <= p5if_pkg::p5if_st_run;
						end
					end
				end
				p5if_pkg::p5if_st_run: begin
					state <= p5if_pkg::p5if_st_run;
				end
				default: begin
					state <= p5if_pkg::p5if_st_cfg;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_source_ref_input <= 1'b0;
			link_clock_present     <= 1'b0;
		end else begin
			if (state == p5if_pkg::p5if_st_cfg && cnt == p5if_pkg::CNT_W'(p5if_pkg::STRAP_SETTLE)) begin
				clock_source_ref_input <= s_src;
			end
			link_clock_present <= state == p5if_pkg::p5if_st_run;
		end
	end

	// Edges of incoming clocks, read only after the second sync stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txclk_d <= 1'b0;
			rxclk_d <= 1'b0;
		end else begin
			txclk_d <= s_txclk;
			rxclk_d <= s_rxclk;
		end
	end
	assign txclk_rise = s_txclk && !txclk_d;
	assign rxclk_rise = s_rxclk && !rxclk_d;

	// MII half period by speed; 50 MHz in RMII
	assign half      = cfg_rmii ? p5if_pkg::DIV_W'(p5if_pkg::RMII_HALF) :
		speed_100 ? p5if_pkg::DIV_W'(p5if_pkg::MII_FAST_HALF) :
		p5if_pkg::DIV_W'(p5if_pkg::MII_SLOW_HALF);
	assign gen_on    = state != p5if_pkg::p5if_st_cfg && p5if_is_gen(mode);
	assign gen_rise  = gen_on && !gclk && div_cnt == half - 1'b1;
	assign next_gclk = !gen_on ? 1'b0 : (div_cnt == half - 1'b1) ? !gclk : gclk;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt                <= '0;
			gclk                   <= 1'b0;
			port5_tx_clock_pin_out <= 1'b0;
			port5_rx_clock_pin_out <= 1'b0;
		end else begin
			div_cnt                <= (!gen_on || div_cnt == half - 1'b1) ? '0 : div_cnt + 1'b1;
			gclk                   <= next_gclk;
			port5_tx_clock_pin_out <= next_gclk && mode == p5if_pkg::p5if_mii_phy;
			port5_rx_clock_pin_out <= next_gclk;
		end
	end

	// PHY-like drives clocks and status; RMII clock mode drives the rx clock pin; else inputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port5_tx_clock_pin_oe  <= 1'b0;
			port5_rx_clock_pin_oe  <= 1'b0;
			port5_collision_pin_oe <= 1'b0;
			port5_carrier_pin_oe   <= 1'b0;
		end else begin
			port5_tx_clock_pin_oe  <= state != p5if_pkg::p5if_st_cfg && mode == p5if_pkg::p5if_mii_phy;
			port5_rx_clock_pin_oe  <= gen_on;
			port5_collision_pin_oe <= state != p5if_pkg::p5if_st_cfg && mode == p5if_pkg::p5if_mii_phy;
			port5_carrier_pin_oe   <= state != p5if_pkg::p5if_st_cfg && mode == p5if_pkg::p5if_mii_phy;
		end
	end

	// one transfer per rising edge; 10 Mbit/s RMII repeats
	always_comb begin
		launch = 1'b0;
		sample = 1'b0;
		if (state == p5if_pkg::p5if_st_run) begin
			launch = gen_on ? gen_rise : (mode == p5if_pkg::p5if_mii_mac) ? rxclk_rise : txclk_rise;
			sample = gen_on ? gen_rise : txclk_rise;
		end
		if (cfg_rmii && !speed_100) begin
			launch = launch && lrep == '0;
			sample = sample && srep == '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrep <= '0;
			srep <= '0;
		end else begin
			if (launch || (lrep != '0 && (gen_on ? gen_rise : txclk_rise))) begin
				lrep <= (lrep == p5if_pkg::REP_W'(p5if_pkg::RMII_SLOW_REP - 1)) ? '0 : lrep + 1'b1;
			end
			if (sample || (srep != '0 && (gen_on ? gen_rise : txclk_rise))) begin
				srep <= (srep == p5if_pkg::REP_W'(p5if_pkg::RMII_SLOW_REP - 1)) ? '0 : srep + 1'b1;
			end
		end
	end

	// RMII sends the low dibit first, pops after the high one
	assign pop = launch && fifo_valid && (!cfg_rmii || out_ph);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port5_rx_valid_pin <= 1'b0;
			port5_rx_error_pin <= 1'b0;
			port5_rx_data_pins <= '0;
			out_ph             <= 1'b0;
		end else if (state != p5if_pkg::p5if_st_run) begin
			port5_rx_valid_pin <= 1'b0;
			port5_rx_error_pin <= 1'b0;
			port5_rx_data_pins <= '0;
			out_ph             <= 1'b0;
		end else if (launch) begin
			// nibble or dibit per clock; valid qualifies it, error only in MII
			port5_rx_valid_pin <= fifo_valid;
			port5_rx_error_pin <= fifo_valid && !cfg_rmii && fifo_word[4];
			if (!fifo_valid) begin
				port5_rx_data_pins <= '0;
				out_ph             <= 1'b0;
			end else if (!cfg_rmii) begin
				port5_rx_data_pins <= fifo_word[3:0];
			end else begin
				// dibits drive the PHY transmit inputs
				port5_rx_data_pins <= {2'h0, out_ph ? fifo_word[3:2] : fifo_word[1:0]};
				out_ph             <= !out_ph;
			end
		end
	end

	// Ingress: sampled partner data toward the switch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ingress_data  <= '0;
			ingress_error <= 1'b0;
			ingress_valid <= 1'b0;
			in_ph         <= 1'b0;
			in_low        <= '0;
		end else begin
			ingress_valid <= 1'b0;
			if (sample) begin
				if (!s_txen) begin
					in_ph <= 1'b0;
				end else if (!cfg_rmii) begin
					ingress_data  <= s_txd;
					ingress_error <= s_txer;
					ingress_valid <= 1'b1;
				end else if (!in_ph) begin
					in_low <= s_txd[1:0];
					in_ph  <= 1'b1;
				end else begin
					ingress_data  <= {s_txd[1:0], in_low};
					ingress_error <= s_txer;
					ingress_valid <= 1'b1;
					in_ph         <= 1'b0;
				end
			end
		end
	end

	// collision when both directions active in half duplex
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port5_carrier_pin_out   <= 1'b0;
			port5_collision_pin_out <= 1'b0;
			carrier_seen            <= 1'b0;
			collision_seen          <= 1'b0;
		end else begin
			port5_carrier_pin_out   <= s_txen || port5_rx_valid_pin;
			port5_collision_pin_out <= half_duplex && s_txen && port5_rx_valid_pin;
			if (mode == p5if_pkg::p5if_mii_mac) begin
				carrier_seen   <= s_crs;
				collision_seen <= s_col;
			end else begin
				carrier_seen   <= s_txen || port5_rx_valid_pin;
				collision_seen <= half_duplex && s_txen && port5_rx_valid_pin;
			end
		end
	end

	sequence s_high2;
		port5_rx_clock_pin_out [*2] ##1 !port5_rx_clock_pin_out;
	endsequence

	sequence s_high4;
		port5_tx_clock_pin_out [*4] ##1 !port5_tx_clock_pin_out;
	endsequence

	property p_phy_dir;
		@(posedge ref_clk) disable iff (!rst_n)
		state == p5if_pkg::p5if_st_run && mode == p5if_pkg::p5if_mii_phy
			|-> port5_tx_clock_pin_oe && port5_collision_pin_oe && port5_carrier_pin_oe;
	endproperty
	a_phy_dir: assert property (p_phy_dir) else $error("PHY-like role not driving");

	property p_mac_dir;
		@(posedge ref_clk) disable iff (!rst_n)
		mode != p5if_pkg::p5if_mii_phy |=> !port5_tx_clock_pin_oe && !port5_carrier_pin_oe;
	endproperty
	a_mac_dir: assert property (p_mac_dir) else $error("Pin driven outside PHY role");

	property p_fast_clk;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(port5_tx_clock_pin_out) && speed_100 && $stable(speed_100) |-> s_high4;
	endproperty
	a_fast_clk: assert property (p_fast_clk) else $error("25 MHz clock high time wrong");

	property p_rmii_clk;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(port5_rx_clock_pin_out) && cfg_rmii |-> s_high2;
	endproperty
	a_rmii_clk: assert property (p_rmii_clk) else $error("50 MHz reference wrong");

	property p_wait_clk;
		@(posedge ref_clk) disable iff (!rst_n)
		state != p5if_pkg::p5if_st_run |=> !port5_rx_valid_pin;
	endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("Data sent before clock ready");

	property p_pop_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		$changed(port5_rx_valid_pin) |-> $past(launch) || $past(state) != p5if_pkg::p5if_st_run;
	endproperty
	a_pop_edge: assert property (p_pop_edge) else $error("Valid moved off clock edge");

	property p_collision;
		@(posedge ref_clk) disable iff (!rst_n)
		half_duplex && s_txen && port5_rx_valid_pin ##1 $stable(half_duplex)
			|-> port5_collision_pin_out;
	endproperty
	a_collision: assert property (p_collision) else $error("Collision not flagged");

	property p_mode_pick;
		@(posedge ref_clk) disable iff (!rst_n)
		state == p5if_pkg::p5if_st_cfg && cnt == p5if_pkg::CNT_W'(p5if_pkg::STRAP_SETTLE)
			|=> cfg_clkmode == ($past(clock_mode_reg_valid) ? $past(clock_mode_reg_bit)
			: $past(s_clkmode));
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("Clock mode choice wrong");

	property p_role_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		state == p5if_pkg::p5if_st_run |=> $stable(cfg_mac) && $stable(cfg_rmii);
	endproperty
	a_role_hold: assert property (p_role_hold) else $error("Role changed after config");
endmodule

// ===== src/p5if_sync.sv
`timescale 1ns/100ps
module p5if_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
